// >>> verilog/mos_origin_search.sv
// origin search and positioning control for one pulse output channel
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "mos_cfg.svh"
// Summary of operation
// - present value set command zeroes value, defines origin
// - search drives pulses, watches origin, proximity, limits
// - start at initial speed, ramp to high speed
// - after proximity ramp to low speed, keep moving
// - origin edge in low phase stops pulses
// - origin return refused while origin undefined
// - absolute positioning refused while origin undefined
// - relative move undefined: zero value then pulse
// - search-only role: limits act during search only
// - always role: limits also act during moves
// - limit polarity follows NC or NO setting
// - hold-origin: limit stops, origin state kept
// - clear-origin: limit stops, origin becomes undefined
// - initial speed accepted from 0 to 100 kpps
// - search needs high above proximity above initial
// - linear curve gives trapezoidal ramps
// - S-curve setting gives S-shaped ramps
// - origin taken on rising edge, configured direction
module mos_origin_search #(
  parameter int RAMP_CYC = `MOS_RAMP_CYC
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // register port
  input wire logic [`MOS_AW-1:0] addr_i,
  input wire logic [`MOS_DW-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [`MOS_DW-1:0] rdata_o,
  // position sensors
  input wire logic org_i,
  input wire logic prox_i,
  input wire logic cw_lim_i,
  input wire logic ccw_lim_i,
  // motor driver
  output logic pulse_o,
  output logic dir_o,
  // status
  output logic origin_defined_o,
  output logic busy_o
);
  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers, order: ccw, cw, prox, org
  logic [3:0] pin_w;
  logic [3:0] s1_r;
  logic [3:0] s2_r;
  logic org_d_r;
  assign pin_w = {ccw_lim_i, cw_lim_i, prox_i, org_i};
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
          s1_r[gi] <= 1'b0;
          s2_r[gi] <= 1'b0;
        end else begin
          s1_r[gi] <= pin_w[gi];
          s2_r[gi] <= s1_r[gi];
        end
      end
    end
  endgenerate
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) org_d_r <= 1'b0;
    else org_d_r <= s2_r[0];
  end

  ////////////////////////////////////////////////////////////////////////
  // registers
  mos_pkg::mos_cfg_t cfg_r;
  mos_pkg::mos_state_t st_r;
  mos_pkg::mos_state_t st_nxt;
  logic [`MOS_SW-1:0] init_r;
  logic [`MOS_SW-1:0] high_r;
  logic [`MOS_SW-1:0] prox_r;
  logic [`MOS_SW-1:0] acc_r;
  logic [`MOS_DW-1:0] tgt_r;
  logic [`MOS_DW-1:0] pv_r;
  logic [`MOS_DW-1:0] pv_nxt;
  logic [`MOS_DW-1:0] rem_r;
  logic [`MOS_DW-1:0] rem_nxt;
  logic dir_r;
  logic dir_nxt;
  logic def_r;
  logic def_nxt;
  logic err_r;
  logic hit_r;
  logic step_r;
  logic [`MOS_SW-1:0] cur_r;
  logic [`MOS_SW-1:0] cur_nxt;
  logic [`MOS_SW-1:0] jerk_r;
  logic [`MOS_SW-1:0] jerk_nxt;
  logic [`MOS_SW-1:0] tick_r;
  logic [`MOS_DW-1:0] rdata_r;

  ////////////////////////////////////////////////////////////////////////
  // register decode
  logic wr_ctrl;
  logic go_srch;
  logic go_pvz;
  logic go_rel;
  logic go_abs;
  logic go_ret;
  logic go_stop;
  logic go_clr;
  logic [`MOS_SW-1:0] spd_wr;
  mos_pkg::mos_stat_t stat_w;
  logic [`MOS_DW-1:0] rd_sel;
  assign wr_ctrl = wr_i && addr_i == `MOS_OFF_CTRL;
  assign go_srch = wr_ctrl && wdata_i[`MOS_CTRL_SRCH];
  assign go_pvz = wr_ctrl && wdata_i[`MOS_CTRL_PVZ];
  assign go_rel = wr_ctrl && wdata_i[`MOS_CTRL_REL];
  assign go_abs = wr_ctrl && wdata_i[`MOS_CTRL_ABS];
  assign go_ret = wr_ctrl && wdata_i[`MOS_CTRL_RET];
  assign go_stop = wr_ctrl && wdata_i[`MOS_CTRL_STOP];
  assign go_clr = wr_ctrl && wdata_i[`MOS_CTRL_CLR];
  // speeds above 100 kpps saturate rather than wrap
  assign spd_wr = (wdata_i > {15'h0000, `MOS_MAX_SPD}) ?
                  `MOS_MAX_SPD : wdata_i[`MOS_SW-1:0];
  assign stat_w = '{state: st_r, lim_hit: hit_r, err: err_r,
                    busy: st_r != mos_pkg::MOS_IDLE, defined: def_r};
  assign rd_sel =
    (addr_i == `MOS_OFF_CFG) ? {27'h0000000, cfg_r} :
    (addr_i == `MOS_OFF_INIT) ? {15'h0000, init_r} :
    (addr_i == `MOS_OFF_HIGH) ? {15'h0000, high_r} :
    (addr_i == `MOS_OFF_PROX) ? {15'h0000, prox_r} :
    (addr_i == `MOS_OFF_ACC) ? {15'h0000, acc_r} :
    (addr_i == `MOS_OFF_TGT) ? tgt_r :
    (addr_i == `MOS_OFF_STAT) ? {24'h000000, stat_w} :
    (addr_i == `MOS_OFF_PV) ? pv_r :
    (addr_i == `MOS_OFF_SPD) ? {15'h0000, cur_r} : 32'h00000000;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_r <= `MOS_CFG_RST;
      init_r <= `MOS_SPD_RST;
      high_r <= `MOS_SPD_RST;
      prox_r <= `MOS_SPD_RST;
      acc_r <= `MOS_ACC_RST;
      tgt_r <= 32'h00000000;
    end else if (wr_i) begin
      if (addr_i == `MOS_OFF_CFG) cfg_r <= wdata_i[`MOS_CFG_W-1:0];
      if (addr_i == `MOS_OFF_INIT) init_r <= spd_wr;
      if (addr_i == `MOS_OFF_HIGH) high_r <= spd_wr;
      if (addr_i == `MOS_OFF_PROX) prox_r <= spd_wr;
      if (addr_i == `MOS_OFF_ACC) acc_r <= spd_wr;
      if (addr_i == `MOS_OFF_TGT) tgt_r <= wdata_i;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) rdata_r <= 32'h00000000;
    else rdata_r <= rd_i ? rd_sel : 32'h00000000;
  end

  ////////////////////////////////////////////////////////////////////////
  // sensors and limits
  logic idle_w;
  logic srch_w;
  logic org_rise;
  logic prox_s;
  logic [1:0] lim_act;
  logic lim_en;
  logic lim_trip;
  logic spd_ok;
  assign idle_w = st_r == mos_pkg::MOS_IDLE;
  assign srch_w = st_r == mos_pkg::MOS_HI || st_r == mos_pkg::MOS_LO;
  assign org_rise = s2_r[0] && !org_d_r;
  assign prox_s = s2_r[1];
  // NC contacts open on a hit, so a low level is the active one
  assign lim_act = cfg_r.lim_no ? s2_r[3:2] : ~s2_r[3:2];
  assign lim_en = srch_w ||
                  (cfg_r.lim_always && st_r == mos_pkg::MOS_MOVE);
  assign lim_trip = lim_en && |lim_act;
  assign spd_ok = high_r > prox_r && prox_r > init_r;

  ////////////////////////////////////////////////////////////////////////
  // motion requests
  logic [`MOS_DW-1:0] mv_delta;
  logic [`MOS_DW-1:0] mv_mag;
  logic abs_req;
  logic err_set;
  logic pg_pulse;
  assign abs_req = go_abs || go_ret;
  assign mv_delta = go_rel ? tgt_r : (go_ret ? 32'h00000000 : tgt_r) - pv_r;
  assign mv_mag = mv_delta[31] ? 32'h00000000 - mv_delta : mv_delta;
  assign err_set = idle_w && !go_srch && !go_rel && abs_req && !def_r ||
                   idle_w && go_srch && !spd_ok;

  always_comb begin
    st_nxt = st_r;
    pv_nxt = pv_r;
    rem_nxt = rem_r;
    dir_nxt = dir_r;
    def_nxt = def_r;
    if (pg_pulse) begin
      pv_nxt = dir_r ? pv_r - 32'h00000001 : pv_r + 32'h00000001;
      rem_nxt = rem_r - 32'h00000001;
    end
    unique case (st_r)
      mos_pkg::MOS_IDLE: begin
        if (go_srch) begin
          if (spd_ok) begin
            st_nxt = mos_pkg::MOS_HI;
            dir_nxt = cfg_r.dir_ccw;
          end
        end else if (go_rel) begin
          if (!def_r) pv_nxt = 32'h00000000;
          if (mv_mag != 32'h00000000) begin
            st_nxt = mos_pkg::MOS_MOVE;
            rem_nxt = mv_mag;
            dir_nxt = mv_delta[31];
          end
        end else if (abs_req && def_r && mv_mag != 32'h00000000) begin
          st_nxt = mos_pkg::MOS_MOVE;
          rem_nxt = mv_mag;
          dir_nxt = mv_delta[31];
        end
      end
      mos_pkg::MOS_HI: begin
        if (prox_s) st_nxt = mos_pkg::MOS_LO;
      end
      mos_pkg::MOS_LO: begin
        if (org_rise) begin
          st_nxt = mos_pkg::MOS_IDLE;
          pv_nxt = 32'h00000000;
          def_nxt = 1'b1;
        end
      end
      mos_pkg::MOS_MOVE: begin
        if (pg_pulse && rem_r == 32'h00000001) st_nxt = mos_pkg::MOS_IDLE;
      end
    endcase
    if (lim_trip) begin
      st_nxt = mos_pkg::MOS_IDLE;
      if (cfg_r.clr_org) def_nxt = 1'b0;
    end
    if (go_stop) st_nxt = mos_pkg::MOS_IDLE;
    if (go_pvz) begin
      pv_nxt = 32'h00000000;
      def_nxt = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= mos_pkg::MOS_IDLE;
      pv_r <= 32'h00000000;
      rem_r <= 32'h00000000;
      dir_r <= 1'b0;
      def_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      pv_r <= pv_nxt;
      rem_r <= rem_nxt;
      dir_r <= dir_nxt;
      def_r <= def_nxt;
    end
  end

  // a set in the same cycle as a clear wins
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      err_r <= 1'b0;
      hit_r <= 1'b0;
    end else begin
      err_r <= err_set || (err_r && !go_clr);
      hit_r <= lim_trip || (hit_r && !go_clr);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // speed profile
  logic tick_w;
  logic [`MOS_SW-1:0] goal_w;
  logic up_w;
  logic [`MOS_SW-1:0] gap_w;
  logic [`MOS_SW-1:0] s1_w;
  logic [`MOS_SW-1:0] jq_w;
  logic [`MOS_SW-1:0] s_step;
  logic [`MOS_SW-1:0] step_w;
  logic [`MOS_SW-1:0] stp_w;
  logic [`MOS_SW:0] jsum_w;
  assign tick_w = tick_r == 17'h00000;
  assign goal_w = (st_r == mos_pkg::MOS_LO) ? prox_r :
                  idle_w ? `MOS_SPD_RST : high_r;
  assign up_w = goal_w > cur_r;
  assign gap_w = up_w ? goal_w - cur_r : cur_r - goal_w;
  // S-curve: step grows with jerk and shrinks as the goal nears
  assign s1_w = jerk_r < acc_r ? jerk_r : acc_r;
  assign jq_w = (gap_w >> 2) + 17'h00001;
  assign s_step = s1_w < jq_w ? s1_w : jq_w;
  assign step_w = cfg_r.s_curve ? s_step : acc_r;
  assign stp_w = step_w > gap_w ? gap_w : step_w;
  assign jsum_w = {1'b0, jerk_r} + {4'h0, acc_r[`MOS_SW-1:3]} + 18'h00001;

  always_comb begin
    cur_nxt = cur_r;
    jerk_nxt = jerk_r;
    if (st_nxt == mos_pkg::MOS_IDLE) begin
      cur_nxt = `MOS_SPD_RST;
    end else if (idle_w) begin
      cur_nxt = init_r;
    end else if (tick_w) begin
      cur_nxt = up_w ? cur_r + stp_w : cur_r - stp_w;
    end
    if (idle_w || gap_w == 17'h00000) begin
      jerk_nxt = 17'h00001;
    end else if (tick_w) begin
      jerk_nxt = (jsum_w > {1'b0, `MOS_MAX_SPD}) ?
                 `MOS_MAX_SPD : jsum_w[`MOS_SW-1:0];
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cur_r <= `MOS_SPD_RST;
      jerk_r <= 17'h00001;
      tick_r <= 17'h00000;
    end else begin
      cur_r <= cur_nxt;
      jerk_r <= jerk_nxt;
      // restart the tick at every start so the first ramp step is a full
      // tick away and the start speed stands for a known time
      tick_r <= (tick_w || idle_w) ? 17'(RAMP_CYC - 1) :
                tick_r - 17'h00001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pulse output
  mos_pulse_gen u_pg (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .run_i(!idle_w),
    .speed_i(cur_r),
    .pulse_o(pg_pulse)
  );
  logic busy_r;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) step_r <= 1'b0;
    else step_r <= pg_pulse && !idle_w;
  end
  // busy kept in its own flop so the pin comes straight from a register
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) busy_r <= 1'b0;
    else busy_r <= st_nxt != mos_pkg::MOS_IDLE;
  end

  assign rdata_o = rdata_r;
  assign pulse_o = step_r;
  assign dir_o = dir_r;
  assign origin_defined_o = def_r;
  assign busy_o = busy_r;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  sequence s_found;
    st_r == mos_pkg::MOS_LO && org_rise && !lim_trip && !go_stop;
  endsequence
  sequence s_home;
    idle_w && pv_r == 32'h00000000 && def_r;
  endsequence
  a_pv_zero_cmd: assert property (go_pvz |=> pv_r == 32'h00000000 && def_r)
    else $error("present value set did not zero the value");
  a_srch_start: assert property (idle_w && go_srch && spd_ok && !go_stop
    |=> st_r == mos_pkg::MOS_HI && cur_r == $past(init_r))
    else $error("search did not start at initial speed");
  a_prox_slow: assert property (st_r == mos_pkg::MOS_HI && prox_s && !lim_trip
    && !go_stop |=> st_r == mos_pkg::MOS_LO)
    else $error("proximity did not start low speed phase");
  a_origin_stop: assert property (s_found |=> s_home)
    else $error("origin edge did not stop and define origin");
  a_ret_refused: assert property (idle_w && go_ret && !go_srch && !go_rel
    && !def_r |=> err_r && idle_w)
    else $error("origin return accepted without origin");
  a_abs_refused: assert property (idle_w && go_abs && !go_srch && !go_rel
    && !def_r |=> err_r && idle_w)
    else $error("absolute move accepted without origin");
  a_rel_undef: assert property (idle_w && go_rel && !go_srch && !go_stop
    && !go_pvz && !def_r && tgt_r != 32'h00000000
    |=> st_r == mos_pkg::MOS_MOVE && pv_r == 32'h00000000)
    else $error("relative move did not zero the value first");
  a_lim_role: assert property (lim_trip |-> srch_w || cfg_r.lim_always)
    else $error("limit acted outside its role");
  a_lim_hold: assert property (lim_trip && !cfg_r.clr_org && !go_pvz
    && !(st_r == mos_pkg::MOS_LO && org_rise)
    |=> idle_w && def_r == $past(def_r))
    else $error("hold origin limit changed origin state");
  a_lim_clear: assert property (lim_trip && cfg_r.clr_org && !go_pvz
    |=> idle_w && !def_r ##1 !step_r)
    else $error("clear origin limit left origin defined");
  a_spd_limit: assert property (init_r <= `MOS_MAX_SPD
    && cur_r <= `MOS_MAX_SPD)
    else $error("speed above 100 kpps");
  a_bad_speeds: assert property (idle_w && go_srch && !spd_ok
    |=> idle_w && err_r)
    else $error("search started with bad speed order");
  a_lin_step: assert property (tick_w && !cfg_r.s_curve && up_w && !idle_w
    && st_nxt == st_r && gap_w > acc_r
    |=> cur_r == $past(cur_r) + $past(acc_r))
    else $error("linear ramp step wrong");
  a_s_step: assert property (tick_w && cfg_r.s_curve && up_w && !idle_w
    && st_nxt == st_r |=> cur_r - $past(cur_r) <= $past(jerk_r))
    else $error("S-curve step above jerk limit");
  a_srch_dir: assert property (srch_w |-> dir_r == cfg_r.dir_ccw)
    else $error("search moving against configured direction");
endmodule
`default_nettype wire

// >>> verilog/mos_cfg.svh
// offsets, field positions, reset values and timing counts of the block
`ifndef MOS_CFG_SVH
`define MOS_CFG_SVH
`define MOS_AW 8
`define MOS_DW 32
`define MOS_SW 17
`define MOS_OFF_CTRL 8'h00
`define MOS_OFF_CFG 8'h04
`define MOS_OFF_INIT 8'h08
`define MOS_OFF_HIGH 8'h0C
`define MOS_OFF_PROX 8'h10
`define MOS_OFF_ACC 8'h14
`define MOS_OFF_TGT 8'h18
`define MOS_OFF_STAT 8'h1C
`define MOS_OFF_PV 8'h20
`define MOS_OFF_SPD 8'h24
`define MOS_CTRL_SRCH 0
`define MOS_CTRL_PVZ 1
`define MOS_CTRL_REL 2
`define MOS_CTRL_ABS 3
`define MOS_CTRL_RET 4
`define MOS_CTRL_STOP 5
`define MOS_CTRL_CLR 6
`define MOS_CFG_W 5
`define MOS_CFG_RST 5'h00
`define MOS_SPD_RST 17'h00000
`define MOS_ACC_RST 17'h00001
`define MOS_MAX_SPD 17'h186A0
`define MOS_CLK_HZ 27'h5F5E100
`define MOS_CLK_MHZ 100
`define MOS_RAMP_US 1000
`define MOS_RAMP_CYC (`MOS_RAMP_US * `MOS_CLK_MHZ)
`endif

// >>> verilog/mos_pkg.sv
// types shared by the origin search block
package mos_pkg;
  typedef enum logic [3:0] {
    MOS_IDLE = 4'h1,
    MOS_HI = 4'h2,
    MOS_LO = 4'h4,
    MOS_MOVE = 4'h8
  } mos_state_t;
  typedef struct packed {
    logic dir_ccw;
    logic s_curve;
    logic clr_org;
    logic lim_no;
    logic lim_always;
  } mos_cfg_t;
  typedef struct packed {
    logic [3:0] state;
    logic lim_hit;
    logic err;
    logic busy;
    logic defined;
  } mos_stat_t;
endpackage

// >>> verilog/mos_pulse_gen.sv
// rate accumulator turning a speed in pps into single-cycle pulses
`timescale 1ns/1ps
`default_nettype none
`include "mos_cfg.svh"
module mos_pulse_gen (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // control
  input wire logic run_i,
  input wire logic [`MOS_SW-1:0] speed_i,
  // pulse
  output logic pulse_o
);
  logic [26:0] acc_r;
  logic [26:0] sum_w;
  logic wrap_w;
  assign sum_w = acc_r + {10'h000, speed_i};
  assign wrap_w = sum_w >= `MOS_CLK_HZ;
  // clearing on stop keeps the first pulse a full period after start
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      acc_r <= 27'h0000000;
      pulse_o <= 1'b0;
    end else if (!run_i) begin
      acc_r <= 27'h0000000;
      pulse_o <= 1'b0;
    end else begin
      acc_r <= wrap_w ? sum_w - `MOS_CLK_HZ : sum_w;
      pulse_o <= wrap_w;
    end
  end
endmodule
`default_nettype wire

// >>> test/mos_axis_model.sv
// motor, origin, proximity and limit sensors seen by the pulse channel
`timescale 1ns/1ps
`default_nettype none
module mos_axis_model #(
  parameter int PROX_POS = 4,
  parameter int ORG_POS = 6,
  parameter int CW_POS = 12,
  parameter int CCW_POS = -50
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // motor drive
  input wire logic pulse_i,
  input wire logic dir_i,
  input wire logic lim_no_i,
  // sensors
  output logic org_o,
  output logic prox_o,
  output logic cw_lim_o,
  output logic ccw_lim_o,
  output logic signed [31:0] pos_o
);
  logic cw_act;
  logic ccw_act;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pos_o <= 32'sh0;
    end else if (pulse_i) begin
      pos_o <= dir_i ? pos_o - 32'sh1 : pos_o + 32'sh1;
    end
  end
  // narrow origin band, so a rising edge only on entry
  assign org_o = (pos_o >= ORG_POS) && (pos_o < ORG_POS + 2);
  assign prox_o = (pos_o >= PROX_POS) && (pos_o < ORG_POS + 4);
  assign cw_act = pos_o >= CW_POS;
  assign ccw_act = pos_o <= CCW_POS;
  // nc contact opens (pin low) when tripped, no contact closes
  assign cw_lim_o = cw_act ~^ lim_no_i;
  assign ccw_lim_o = ccw_act ~^ lim_no_i;
endmodule
`default_nettype wire

// >>> test/mos_origin_search_test.sv
// bench for the origin search block: registers, search and limited moves
`timescale 1ns/1ps
`default_nettype none
`include "mos_cfg.svh"
module mos_origin_search_test;
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic [31:0] wd;
    logic [31:0] exp;
  } mos_row_t;
  localparam int RAMP = 20;
  localparam int ORG_POS = 6;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [`MOS_AW-1:0] addr_i = 8'h00;
  logic [`MOS_DW-1:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [`MOS_DW-1:0] rdata_o;
  logic org_i, prox_i, cw_lim_i, ccw_lim_i;
  logic pulse_o, dir_o, origin_defined_o, busy_o;
  logic lim_no = 1'b0;
  logic signed [31:0] pos;
  logic [31:0] rd_v;
  int err_total = 0;
  int num_checks = 0;
  int cyc = 0;
  int last_p = 0;
  int gap = 0;
  mos_row_t rows [8];
  ////////////////////////////////////////////////////////////////////////////
  mos_origin_search #(.RAMP_CYC(RAMP)) dut (
    .mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .org_i(org_i),
    .prox_i(prox_i), .cw_lim_i(cw_lim_i), .ccw_lim_i(ccw_lim_i),
    .pulse_o(pulse_o), .dir_o(dir_o), .origin_defined_o(origin_defined_o),
    .busy_o(busy_o));
  mos_axis_model #(.ORG_POS(ORG_POS)) model (
    .mclk_i(mclk_i), .rst_i(rst_i), .pulse_i(pulse_o), .dir_i(dir_o),
    .lim_no_i(lim_no), .org_o(org_i), .prox_o(prox_i),
    .cw_lim_o(cw_lim_i), .ccw_lim_o(ccw_lim_i), .pos_o(pos));
  always #5 mclk_i = ~mclk_i;
  // spacing of the last two steps gives the speed in force
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (pulse_o === 1'b1) begin
      gap <= cyc - last_p;
      last_p <= cyc;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask
  // data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge mclk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    rd_v = rdata_o;
  endtask
  task automatic wait_idle();
    int n;
    for (n = 0; n < 80000; n++) begin
      @(posedge mclk_i);
      #1;
      if (busy_o === 1'b0) break;
    end
    if (n == 80000) begin
      err_total++;
      $display("MISMATCH t=%0t busy never dropped", $time);
      close_out();
    end
  endtask
  task automatic refuse(input logic [31:0] cmd);
    wr(8'h00, 32'h40);
    wr(8'h00, cmd);
    rd(8'h1C);
    chk(rd_v & 32'h6, 32'h4, "command not refused");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rows[0] = '{8'h04, 1'b0, 32'h0, 32'h0};
    rows[1] = '{8'h14, 1'b0, 32'h0, 32'h1};
    rows[2] = '{8'h04, 1'b1, 32'h1F, 32'h1F};
    rows[3] = '{8'h08, 1'b1, 32'h1F4, 32'h1F4};
    rows[4] = '{8'h0C, 1'b1, 32'h1FFFF, 32'h186A0};
    rows[5] = '{8'h20, 1'b1, 32'h5, 32'h0};
    rows[6] = '{8'h3C, 1'b1, 32'h7, 32'h0};
    rows[7] = '{8'h1C, 1'b0, 32'h0, 32'h10};
    repeat (8) @(posedge mclk_i);
    rst_i <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].wr) wr(rows[i].addr, rows[i].wd);
      rd(rows[i].addr);
      chk(rd_v, rows[i].exp, "register row");
    end
    // second reset in mid-run must wipe the settings
    @(posedge mclk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    #1;
    chk({28'h0, busy_o, origin_defined_o, pulse_o, dir_o}, 32'h0, "reset");
    rd(8'h04);
    chk(rd_v, 32'h0, "cfg after reset");
    wr(8'h08, 32'h4E20);
    wr(8'h0C, 32'h186A0);
    wr(8'h10, 32'h186A0);
    wr(8'h14, 32'h9C40);
    refuse(32'h01);
    refuse(32'h10);
    refuse(32'h08);
    wr(8'h10, 32'hC350);
    wr(8'h00, 32'h02);
    @(posedge mclk_i);
    #1;
    chk({31'h0, origin_defined_o}, 32'h1, "origin not defined");
    // search in the cw direction
    wr(8'h00, 32'h41);
    rd(8'h24);
    chk(rd_v, 32'h4E20, "start speed");
    chk({30'h0, busy_o, dir_o}, 32'h2, "search start");
    wait_idle();
    chk(pos, ORG_POS, "stop position");
    chk(((gap >= 1999) && (gap <= 2001)) ? 32'h1 : 32'h0, 32'h1,
        "low phase step spacing");
    chk({31'h0, origin_defined_o}, 32'h1, "search origin flag");
    rd(8'h20);
    chk(rd_v, 32'h0, "search present value");
    // limits always act, clearing the origin
    wr(8'h04, 32'h0D);
    wr(8'h18, 32'h64);
    wr(8'h00, 32'h04);
    wait_idle();
    chk(pos, 32'hC, "always role stop");
    chk({31'h0, origin_defined_o}, 32'h0, "origin kept");
    rd(8'h20);
    chk(rd_v, pos - ORG_POS, "value at limit");
    // search-only role: a tripped limit must not block a move
    wr(8'h04, 32'h00);
    wr(8'h18, 32'hFFFFFFFD);
    wr(8'h00, 32'h04);
    @(posedge mclk_i);
    #1;
    chk({31'h0, dir_o}, 32'h1, "direction of move");
    wait_idle();
    rd(8'h20);
    chk(rd_v, 32'hFFFFFFFD, "relative move value");
    chk(pos, 32'h9, "search-only role move");
    // no contacts, hold origin
    lim_no <= 1'b1;
    wr(8'h04, 32'h03);
    wr(8'h00, 32'h02);
    rd(8'h20);
    chk(rd_v, 32'h0, "value zeroed");
    wr(8'h18, 32'hA);
    wr(8'h00, 32'h04);
    wait_idle();
    chk(pos, 32'hC, "no contact stop");
    chk({31'h0, origin_defined_o}, 32'h1, "origin lost");
    rd(8'h20);
    chk(rd_v, 32'h3, "held value");
    close_out();
  end
endmodule
`default_nettype wire
